// [hw/sdi_pkg.sv]
// constants shared by the sdram direct interface block
package sdi_pkg;

   // timing: core clock and bus clock half period
   localparam int unsigned SDI_CLK_PERIOD_NS = 4;
   localparam int unsigned SDI_BUS_HALF_NS = 32;
   localparam int unsigned SDI_BUS_HALF_CYC = SDI_BUS_HALF_NS / SDI_CLK_PERIOD_NS;

   // apb register byte offsets
   localparam logic [7:0] SDI_OFF_CTRL = 8'h00;
   localparam logic [7:0] SDI_OFF_ADDR = 8'h04;
   localparam logic [7:0] SDI_OFF_CMD = 8'h08;
   localparam logic [7:0] SDI_OFF_STATUS = 8'h0c;
   localparam logic [7:0] SDI_OFF_BUF = 8'h20;
   localparam int unsigned SDI_BUF_WORDS = 8;

   // sdram_control_word fields (control register)
   localparam int SDI_CTRL_TYPE_LSB = 0;
   localparam int SDI_CTRL_W32 = 3;
   localparam int SDI_CTRL_AMX_LSB = 4;
   localparam int SDI_CTRL_LITTLE = 8;
   localparam int SDI_CTRL_RATIO1 = 9;
   localparam int SDI_CTRL_CAS_LSB = 10;
   localparam logic [31:0] SDI_CTRL_RESET = 32'h0000_0408;

   // command register fields
   localparam int SDI_CMD_OP_LSB = 0;
   localparam int SDI_CMD_BE_LSB = 4;
   localparam int SDI_CMD_BURST = 8;
   localparam int SDI_CMD_AUTOPRE = 9;

   // status register fields
   localparam int SDI_ST_BUSY = 0;
   localparam int SDI_ST_REFUSED = 1;
   localparam int SDI_ST_SELF = 2;

   // memory_type_select codes
   localparam logic [2:0] SDI_TYPE_AREA3 = 3'b010;
   localparam logic [2:0] SDI_TYPE_BOTH = 3'b011;

   // address multiplex codes with {bus is 32 bits, addr_mux_select}
   localparam logic [4:0] SDI_AMX32_4M16 = 5'b1_1101;
   localparam logic [4:0] SDI_AMX32_2M16 = 5'b1_0101;
   localparam logic [4:0] SDI_AMX32_1M16 = 5'b1_0100;
   localparam logic [4:0] SDI_AMX32_512K32 = 5'b1_0111;
   localparam logic [4:0] SDI_AMX16_8M16 = 5'b0_1110;
   localparam logic [4:0] SDI_AMX16_4M16 = 5'b0_1101;
   localparam logic [4:0] SDI_AMX16_2M16 = 5'b0_0101;
   localparam int SDI_LH_PIN_32 = 12;
   localparam int SDI_LH_PIN_16 = 11;
   localparam int SDI_MUX_TOP_PIN = 16;
   localparam int SDI_UPPER_BIT = 25;
   localparam int SDI_AREA_BIT = 26;

   // burst geometry: 16 bytes per cache line transfer
   localparam logic [3:0] SDI_BEATS_32 = 4'd4;
   localparam logic [3:0] SDI_BEATS_16 = 4'd8;

   // software operations
   typedef enum logic [3:0] {
      SDI_OP_NOP = 4'h0,
      SDI_OP_REF = 4'h1,
      SDI_OP_SELF = 4'h2,
      SDI_OP_PRECHARGE_ALL_CMD = 4'h3,
      SDI_OP_READ = 4'h4,
      SDI_OP_WRITE = 4'h5,
      SDI_OP_MRS = 4'h6
   } sdi_op_e;

   // pin commands as active-high {row, column, write} strobes
   localparam logic [2:0] SDI_PIN_NOP = 3'b000;
   localparam logic [2:0] SDI_PIN_REF = 3'b110;
   localparam logic [2:0] SDI_PIN_PRECHARGE_ALL_CMD = 3'b101;
   localparam logic [2:0] SDI_PIN_BANK_ACTIVATE_CMD = 3'b100;
   localparam logic [2:0] SDI_PIN_READ = 3'b010;
   localparam logic [2:0] SDI_PIN_WRITE = 3'b011;
   localparam logic [2:0] SDI_PIN_MRS = 3'b111;

endpackage

// [hw/sdi_sync.sv]
// two flip-flop synchroniser, one stage pair per bit
`timescale 1ns/1ps
module sdi_sync #(
   parameter int W = 32
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // data
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta;

   // first stage feeds only the second
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               meta[i] <= 1'b0;
               q_o[i] <= 1'b0;
            end else begin
               meta[i] <= d_i[i];
               q_o[i] <= meta[i];
            end
         end
      end
   endgenerate
endmodule

// [hw/sdi_sdram_direct_interface.sv]
// sdram direct interface: apb registers, command sequencer, address mux, pins
`timescale 1ns/1ps
module sdi_sdram_direct_interface
   import sdi_pkg::*;
#(
   parameter int unsigned BUS_HALF = SDI_BUS_HALF_CYC
) (
   // clock and reset
   input wire logic CLK_I,
   input wire logic RST_N_I,
   // apb slave
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   // sdram clock and control pins
   output logic BUS_CLOCK_OUT_O,
   output logic CKE_O,
   output logic AREA_TWO_SELECT_N_O,
   output logic AREA_THREE_SELECT_N_O,
   output logic ROW_STROBE_LOWER_N_O,
   output logic ROW_STROBE_UPPER_N_O,
   output logic COL_STROBE_LOWER_N_O,
   output logic COL_STROBE_UPPER_N_O,
   output logic RD_WR_O,
   output logic [3:0] BYTE_MASK_O,
   output logic [25:0] ADDR_O,
   // sdram data pins
   input wire logic [31:0] DATA_I,
   output logic [31:0] DATA_O,
   output logic DATA_OE_O
);

   generate
      if (BUS_HALF < 3) begin : g_bad_half
         $error("BUS_HALF must be at least 3 so read data clears the synchroniser");
      end
   endgenerate

   typedef enum {ST_IDLE, ST_ACT, ST_COL, ST_WAITD, ST_GAP, ST_SELF} sdi_state_e;

   // control register fields
   logic [2:0] mem_type;
   logic bus_w32;
   logic [3:0] amx;
   logic little;
   logic ratio_one;
   logic [1:0] cas_lat;
   logic [26:0] addr_reg;
   logic refused;
   // command latched from software
   logic go;
   logic [3:0] cmd_op;
   logic [3:0] cmd_be;
   logic cmd_burst;
   logic cmd_autopre;
   // sequencer
   sdi_state_e state;
   sdi_state_e next_state;
   logic [3:0] beat;
   logic [1:0] cnt;
   logic [31:0] dbuf [0:SDI_BUF_WORDS-1];
   // bus clock divider
   logic [7:0] div_cnt;
   logic tick;
   // apb helpers
   logic acc;
   logic wr;
   logic accept;
   logic cmd_ok;
   logic [31:0] next_rdata;
   logic next_err;
   logic [31:0] data_sync;
   // next pin values
   logic [2:0] next_cmd;
   logic next_both;
   logic next_cke;
   logic [25:0] next_pins;
   logic [31:0] next_dout;
   logic next_oe;
   logic next_take;
   logic capture;
   logic [3:0] beats_n;
   logic last_beat;
   logic [26:0] col_la;
   logic [2:0] off;
   logic only_lower;
   logic [3:0] dqm_lanes;

   ////////////////////////////////////////////////////////////////////////
   // apb slave: one wait state, answer from flops

   assign acc = PSEL_I & PENABLE_I & PREADY_O;
   assign wr = acc & PWRITE_I;
   // self-refresh must accept its exit command, so it is not treated as busy
   assign accept = wr & (PADDR_I == SDI_OFF_CMD) & ~go & (state == ST_IDLE || state == ST_SELF);

   // read decode for the access phase
   always_comb begin
      next_rdata = 32'h0000_0000;
      next_err = 1'b0;
      if (PADDR_I == SDI_OFF_CTRL) begin
         next_rdata = {20'h00000, cas_lat, ratio_one, little, amx, bus_w32, mem_type};
      end else if (PADDR_I == SDI_OFF_ADDR) begin
         next_rdata = {5'h00, addr_reg};
      end else if (PADDR_I == SDI_OFF_CMD) begin
         next_rdata = {22'h000000, cmd_autopre, cmd_burst, cmd_be, cmd_op};
      end else if (PADDR_I == SDI_OFF_STATUS) begin
         next_rdata = {29'h00000000, state == ST_SELF, refused,
                       go | (state != ST_IDLE && state != ST_SELF)};
      end else if (PADDR_I[7:5] == SDI_OFF_BUF[7:5] && PADDR_I[1:0] == 2'b00) begin
         next_rdata = dbuf[PADDR_I[4:2]];
      end else begin
         next_err = 1'b1; // unmapped offset
      end
   end

   // pready toggles high for one cycle after the first access cycle
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         PREADY_O <= 1'b0;
         PRDATA_O <= 32'h0000_0000;
         PSLVERR_O <= 1'b0;
      end else begin
         PREADY_O <= PSEL_I & PENABLE_I & ~PREADY_O;
         PRDATA_O <= (PSEL_I & PENABLE_I & ~PREADY_O & ~PWRITE_I) ? next_rdata : 32'h0000_0000;
         PSLVERR_O <= PSEL_I & PENABLE_I & ~PREADY_O & next_err;
      end
   end

   // control and address registers
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         mem_type <= SDI_CTRL_RESET[SDI_CTRL_TYPE_LSB +: 3];
         bus_w32 <= SDI_CTRL_RESET[SDI_CTRL_W32];
         amx <= SDI_CTRL_RESET[SDI_CTRL_AMX_LSB +: 4];
         little <= SDI_CTRL_RESET[SDI_CTRL_LITTLE];
         ratio_one <= SDI_CTRL_RESET[SDI_CTRL_RATIO1];
         cas_lat <= SDI_CTRL_RESET[SDI_CTRL_CAS_LSB +: 2];
         addr_reg <= 27'h0000000;
      end else if (wr && PADDR_I == SDI_OFF_CTRL) begin
         mem_type <= PWDATA_I[SDI_CTRL_TYPE_LSB +: 3];
         bus_w32 <= PWDATA_I[SDI_CTRL_W32];
         amx <= PWDATA_I[SDI_CTRL_AMX_LSB +: 4];
         little <= PWDATA_I[SDI_CTRL_LITTLE];
         ratio_one <= PWDATA_I[SDI_CTRL_RATIO1];
         cas_lat <= PWDATA_I[SDI_CTRL_CAS_LSB +: 2];
      end else if (wr && PADDR_I == SDI_OFF_ADDR) begin
         addr_reg <= PWDATA_I[26:0];
      end
   end

   // an access is legal only into sdram space and away from 1:1 ratio
   always_comb begin
      cmd_ok = 1'b0;
      if (mem_type == SDI_TYPE_BOTH) begin
         cmd_ok = 1'b1;
      end else if (mem_type == SDI_TYPE_AREA3) begin
         cmd_ok = addr_reg[SDI_AREA_BIT] | (PWDATA_I[SDI_CMD_OP_LSB +: 4] != SDI_OP_READ
                  && PWDATA_I[SDI_CMD_OP_LSB +: 4] != SDI_OP_WRITE);
      end
      if (ratio_one) begin
         cmd_ok = 1'b0;
      end
      if (PWDATA_I[SDI_CMD_OP_LSB +: 4] == SDI_OP_NOP) begin
         cmd_ok = 1'b1; // nop only leaves self-refresh
      end
   end

   // refused flag: a new refusal wins over a clear in the same cycle
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         refused <= 1'b0;
      end else if (accept && !cmd_ok) begin
         refused <= 1'b1;
      end else if (wr && PADDR_I == SDI_OFF_STATUS && PWDATA_I[SDI_ST_REFUSED]) begin
         refused <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // bus clock: divided from the core clock, commands change on its fall

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         div_cnt <= 8'h00;
         BUS_CLOCK_OUT_O <= 1'b0;
      end else if (div_cnt == 8'(BUS_HALF - 1)) begin
         div_cnt <= 8'h00;
         BUS_CLOCK_OUT_O <= ~BUS_CLOCK_OUT_O;
      end else begin
         div_cnt <= div_cnt + 8'h01;
      end
   end
   assign tick = (div_cnt == 8'(BUS_HALF - 1)) & BUS_CLOCK_OUT_O;

   // read data pins are asynchronous to the core clock
   sdi_sync #(.W(32)) u_data_sync (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .d_i(DATA_I),
      .q_o(data_sync)
   );

   ////////////////////////////////////////////////////////////////////////
   // address multiplexer

   // returns pin values for a row or column phase
   function automatic logic [25:0] mux_pins(input logic [26:0] la, input logic is_row,
                                             input logic lh_val, input logic lh_force,
                                             input logic [4:0] sel);
      int rs;
      int top;
      int lh;
      logic [25:0] p;
      p = la[25:0];
      lh = sel[4] ? SDI_LH_PIN_32 : SDI_LH_PIN_16;
      if (sel == SDI_AMX32_4M16 || sel == SDI_AMX16_4M16 || sel == SDI_AMX32_2M16
          || sel == SDI_AMX16_2M16) begin
         rs = 9;
         top = (sel == SDI_AMX32_4M16) ? SDI_MUX_TOP_PIN : SDI_MUX_TOP_PIN - 1;
      end else if (sel == SDI_AMX16_8M16) begin
         rs = 10;
         top = SDI_MUX_TOP_PIN - 1;
      end else if (sel == SDI_AMX32_512K32) begin
         rs = 8;
         top = SDI_MUX_TOP_PIN - 2;
      end else begin
         rs = 8;
         top = sel[4] ? SDI_MUX_TOP_PIN - 1 : SDI_MUX_TOP_PIN - 2;
      end
      for (int i = 1; i <= SDI_MUX_TOP_PIN; i++) begin
         if (i > top) begin
            p[i] = 1'b0;
         end else if (i == lh && (!is_row || lh_force)) begin
            p[i] = lh_val;
         end else if (is_row || i > lh + 1) begin
            p[i] = la[i + rs];
         end else begin
            p[i] = la[i];
         end
      end
      return p;
   endfunction

   // beat geometry: 16 bytes per line, wrapping from the requested word
   assign beats_n = bus_w32 ? SDI_BEATS_32 : SDI_BEATS_16;
   assign last_beat = ~cmd_burst | (beat == beats_n - 4'd1);
   always_comb begin
      off = 3'(beat) + (bus_w32 ? {1'b0, addr_reg[3:2]} : addr_reg[3:1]);
      if (bus_w32) begin
         col_la = {addr_reg[26:4], off[1:0], addr_reg[1:0]};
      end else begin
         col_la = {addr_reg[26:4], off[2:0], addr_reg[0]};
      end
   end
   assign only_lower = ({bus_w32, amx} == SDI_AMX32_4M16) || ({bus_w32, amx} == SDI_AMX16_8M16);

   // lane enables for the endian mode, low enables the byte
   always_comb begin
      if (little) begin
         dqm_lanes = ~cmd_be;
      end else begin
         dqm_lanes = ~{cmd_be[0], cmd_be[1], cmd_be[2], cmd_be[3]};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // command sequencer

   // next command and state, evaluated at each bus clock fall
   always_comb begin
      next_cmd = SDI_PIN_NOP;
      next_both = 1'b0;
      next_cke = 1'b1;
      next_pins = ADDR_O;
      next_dout = DATA_O;
      next_oe = 1'b0;
      next_take = 1'b0;
      next_state = state;
      capture = 1'b0;
      case (state)
         ST_IDLE: begin
            if (go) begin
               next_take = 1'b1;
               if (cmd_op == SDI_OP_READ || cmd_op == SDI_OP_WRITE) begin
                  next_cmd = SDI_PIN_BANK_ACTIVATE_CMD;
                  next_pins = mux_pins(addr_reg, 1'b1, 1'b0, 1'b0, {bus_w32, amx});
                  next_state = ST_ACT;
               end else if (cmd_op == SDI_OP_REF) begin
                  next_cmd = SDI_PIN_REF;
                  next_both = 1'b1;
                  next_state = ST_GAP;
               end else if (cmd_op == SDI_OP_SELF) begin
                  next_cmd = SDI_PIN_REF;
                  next_both = 1'b1;
                  next_cke = 1'b0;
                  next_state = ST_SELF;
               end else if (cmd_op == SDI_OP_PRECHARGE_ALL_CMD) begin
                  next_cmd = SDI_PIN_PRECHARGE_ALL_CMD;
                  next_pins = mux_pins(addr_reg, 1'b1, 1'b1, 1'b1, {bus_w32, amx});
                  next_state = ST_GAP;
               end else if (cmd_op == SDI_OP_MRS) begin
                  next_cmd = SDI_PIN_MRS; // mode value comes from software
                  next_both = 1'b1;
                  next_pins = addr_reg[25:0];
                  next_state = ST_GAP;
               end
            end
         end
         ST_ACT, ST_COL: begin
            // auto-precharge only on the last beat when requested
            next_pins = mux_pins(col_la, 1'b0, cmd_autopre & last_beat, 1'b0, {bus_w32, amx});
            if (cmd_op == SDI_OP_READ) begin
               next_cmd = SDI_PIN_READ; // one datum per column command
               next_state = ST_WAITD;
            end else begin
               next_cmd = SDI_PIN_WRITE;
               next_dout = dbuf[beat[2:0]];
               next_oe = 1'b1;
               next_state = last_beat ? ST_GAP : ST_COL;
            end
         end
         ST_WAITD: begin
            if (cnt == 2'd0) begin
               capture = 1'b1;
               next_state = last_beat ? ST_IDLE : ST_COL;
            end
         end
         ST_GAP: begin
            next_state = ST_IDLE;
         end
         ST_SELF: begin
            next_cke = 1'b0;
            if (go) begin
               next_take = 1'b1;
               next_cke = 1'b1;
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // state, beat and latency counters, command latch
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         state <= ST_IDLE;
         go <= 1'b0;
         beat <= 4'h0;
         cnt <= 2'd0;
         cmd_op <= 4'h0;
         cmd_be <= 4'h0;
         cmd_burst <= 1'b0;
         cmd_autopre <= 1'b0;
      end else begin
         if (accept && cmd_ok && (state != ST_SELF || PWDATA_I[3:0] == SDI_OP_NOP)) begin
            go <= 1'b1;
            cmd_op <= PWDATA_I[SDI_CMD_OP_LSB +: 4];
            cmd_be <= PWDATA_I[SDI_CMD_BE_LSB +: 4];
            cmd_burst <= PWDATA_I[SDI_CMD_BURST];
            cmd_autopre <= PWDATA_I[SDI_CMD_AUTOPRE];
         end else if (tick && next_take) begin
            go <= 1'b0;
         end
         if (tick) begin
            state <= next_state;
            if (state == ST_IDLE) begin
               beat <= 4'h0;
            end else if ((state == ST_COL || state == ST_ACT) && cmd_op == SDI_OP_WRITE) begin
               beat <= beat + 4'h1;
            end else if (capture) begin
               beat <= beat + 4'h1;
            end
            if (state == ST_ACT || state == ST_COL) begin
               cnt <= cas_lat; // data lags the read by the cas latency
            end else if (cnt != 2'd0) begin
               cnt <= cnt - 2'd1;
            end
         end
      end
   end

   // data buffer: software access and read capture
   always_ff @(posedge CLK_I) begin
      if (tick && capture) begin
         dbuf[beat[2:0]] <= bus_w32 ? data_sync : {16'h0000, data_sync[15:0]};
      end else if (wr && PADDR_I[7:5] == SDI_OFF_BUF[7:5]) begin
         dbuf[PADDR_I[4:2]] <= PWDATA_I;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pin registers, updated on the bus clock fall

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         CKE_O <= 1'b1;
         AREA_TWO_SELECT_N_O <= 1'b1;
         AREA_THREE_SELECT_N_O <= 1'b1;
         ROW_STROBE_LOWER_N_O <= 1'b1;
         ROW_STROBE_UPPER_N_O <= 1'b1;
         COL_STROBE_LOWER_N_O <= 1'b1;
         COL_STROBE_UPPER_N_O <= 1'b1;
         RD_WR_O <= 1'b1;
         BYTE_MASK_O <= 4'hf;
         ADDR_O <= 26'h0000000;
         DATA_O <= 32'h0000_0000;
         DATA_OE_O <= 1'b0;
      end else if (tick) begin
         CKE_O <= next_cke;
         // selects only frame real commands, nop leaves the chips deaf
         AREA_TWO_SELECT_N_O <= ~((next_cmd != SDI_PIN_NOP) && mem_type == SDI_TYPE_BOTH
                                  && (next_both || !addr_reg[SDI_AREA_BIT]));
         AREA_THREE_SELECT_N_O <= ~((next_cmd != SDI_PIN_NOP)
                                    && (next_both || addr_reg[SDI_AREA_BIT]));
         ROW_STROBE_LOWER_N_O <= ~(next_cmd[2] && (next_both || only_lower
                                  || !addr_reg[SDI_UPPER_BIT]));
         ROW_STROBE_UPPER_N_O <= ~(next_cmd[2] && (next_both || (!only_lower
                                  && addr_reg[SDI_UPPER_BIT])));
         COL_STROBE_LOWER_N_O <= ~(next_cmd[1] && (next_both || only_lower
                                  || !addr_reg[SDI_UPPER_BIT]));
         COL_STROBE_UPPER_N_O <= ~(next_cmd[1] && (next_both || (!only_lower
                                  && addr_reg[SDI_UPPER_BIT])));
         RD_WR_O <= ~next_cmd[0]; // low marks a write, a precharge-all or a mode register set
         // reads fetch the whole bus width, writes only enabled bytes
         if (next_cmd == SDI_PIN_WRITE) begin
            BYTE_MASK_O <= bus_w32 ? dqm_lanes : {2'b11, dqm_lanes[1:0]};
         end else begin
            BYTE_MASK_O <= bus_w32 ? 4'h0 : 4'hc;
         end
         ADDR_O <= next_pins;
         DATA_O <= next_dout;
         DATA_OE_O <= next_oe;
      end
   end

endmodule

// [testbench/sdi_asserts.sv]
// concurrent pin checks
`timescale 1ns/1ps
module sdi_asserts
   import sdi_pkg::*;
#(
   parameter int unsigned BUS_HALF = SDI_BUS_HALF_CYC
) (
   // clock and reset
   input wire logic CLK_I,
   input wire logic RST_N_I,
   // sdram pins
   input wire logic BUS_CLOCK_OUT_O,
   input wire logic CKE_O,
   input wire logic AREA_TWO_SELECT_N_O,
   input wire logic AREA_THREE_SELECT_N_O,
   input wire logic ROW_STROBE_LOWER_N_O,
   input wire logic ROW_STROBE_UPPER_N_O,
   input wire logic COL_STROBE_LOWER_N_O,
   input wire logic COL_STROBE_UPPER_N_O,
   input wire logic [25:0] ADDR_O
);
   localparam int PM1 = 2 * BUS_HALF - 1;
   logic [25:0] row_a;
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);
   ////////
   // row address for the column compare
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         row_a <= '0;
      end else if (!ROW_STROBE_LOWER_N_O && COL_STROBE_LOWER_N_O) begin
         row_a <= ADDR_O;
      end
   end
   ////////
   a_dual_strobe: assert property (!ROW_STROBE_LOWER_N_O && !COL_STROBE_LOWER_N_O
      |-> !ROW_STROBE_UPPER_N_O && !COL_STROBE_UPPER_N_O) else $error("half strobe");
   a_single_half: assert property (!ROW_STROBE_LOWER_N_O && COL_STROBE_LOWER_N_O
      && COL_STROBE_UPPER_N_O |-> ROW_STROBE_UPPER_N_O) else $error("both row halves");
   a_self_entry: assert property ($fell(CKE_O) |-> !ROW_STROBE_LOWER_N_O
      && !COL_STROBE_LOWER_N_O) else $error("cke low outside self");
   a_cke_edge: assert property ($changed(CKE_O) |-> $fell(BUS_CLOCK_OUT_O))
      else $error("cke off a fall");
   a_pin_timing: assert property ($changed(ROW_STROBE_LOWER_N_O)
      |-> $fell(BUS_CLOCK_OUT_O)) else $error("strobe off a fall");
   a_cmd_period: assert property ($fell(AREA_THREE_SELECT_N_O)
      |-> ##PM1 !AREA_THREE_SELECT_N_O) else $error("short select");
   a_sel_shared: assert property (!ROW_STROBE_LOWER_N_O || !COL_STROBE_LOWER_N_O
      |-> !AREA_TWO_SELECT_N_O || !AREA_THREE_SELECT_N_O) else $error("no select");
   a_fixed_bits: assert property ($fell(COL_STROBE_LOWER_N_O) && ROW_STROBE_LOWER_N_O
      |-> ADDR_O[25:17] == row_a[25:17] && ADDR_O[0] == row_a[0]) else $error("pins moved");
endmodule
bind sdi_sdram_direct_interface sdi_asserts #(.BUS_HALF(BUS_HALF)) sdi_asserts_inst (.*);

// [testbench/sdi_sdram_model.sv]
// behavioural sdram model
`timescale 1ns/1ps
module sdi_sdram_model #(
   parameter int CAS = 1
) (
   // controller pins
   input wire logic clk_i,
   input wire logic cke_i,
   input wire logic s2_n_i,
   input wire logic s3_n_i,
   input wire logic rl_n_i,
   input wire logic ru_n_i,
   input wire logic cl_n_i,
   input wire logic cu_n_i,
   input wire logic we_n_i,
   input wire logic [3:0] dqm_i,
   input wire logic [25:0] a_i,
   input wire logic [31:0] dq_i,
   // read data back
   output logic [31:0] dq_o = 32'h0
);
   logic [31:0] mem [logic [25:0]];
   logic [25:0] row_a, col_a, mrs_a;
   logic [31:0] rd_v;
   logic [3:0] last_mask;
   logic row_up, drv = 1'b0;
   int wcount = 0, cnt = 0;
   ////////
   // capture under a select only
   always @(posedge clk_i) begin
      logic r, c;
      logic [31:0] v;
      r = !rl_n_i || !ru_n_i;
      c = !cl_n_i || !cu_n_i;
      // data stands one period, then garbage
      if (cnt > 0 && --cnt == 0) begin
         dq_o <= rd_v;
         drv <= 1'b1;
      end else if (drv) begin
         dq_o <= ~dq_o;
         drv <= 1'b0;
      end
      v = mem.exists(a_i) ? mem[a_i] : 32'h0;
      if (cke_i && !(s2_n_i && s3_n_i)) begin
         if (r && !c && we_n_i) begin
            row_a <= a_i;
            row_up <= !ru_n_i;
         end else if (c && !r && we_n_i) begin
            col_a <= a_i;
            rd_v <= v;
            cnt = CAS;
         end else if (c && !r) begin
            col_a <= a_i;
            last_mask <= dqm_i;
            wcount++;
            // low mask lanes only
            for (int k = 0; k < 4; k++) if (!dqm_i[k]) v[8*k +: 8] = dq_i[8*k +: 8];
            mem[a_i] = v;
         end else if (r && c && !we_n_i) begin
            mrs_a <= a_i;
         end
      end
   end
endmodule

// [testbench/tb.sv]
// self-checking bench
`timescale 1ns/1ps
module tb import sdi_pkg::*;;
   logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwd = 32'h0, prd, dq_in, dq_out, rdata;
   logic rdy, perr, err, bclk, cke, s2_n, s3_n, rl_n, ru_n, cl_n, cu_n, we_n, oe;
   logic [3:0] dqm;
   logic [25:0] addr;
   int bad_count = 0, n_tests = 0;
   localparam logic [31:0] A = 32'h0402_4a58;
   always #2 clk = ~clk;
   sdi_sdram_direct_interface sdi_sdram_direct_interface_inst (.CLK_I(clk), .RST_N_I(rst_n),
      .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwd),
      .PRDATA_O(prd), .PREADY_O(rdy), .PSLVERR_O(perr), .BUS_CLOCK_OUT_O(bclk), .CKE_O(cke),
      .AREA_TWO_SELECT_N_O(s2_n), .AREA_THREE_SELECT_N_O(s3_n), .ROW_STROBE_LOWER_N_O(rl_n),
      .ROW_STROBE_UPPER_N_O(ru_n), .COL_STROBE_LOWER_N_O(cl_n), .COL_STROBE_UPPER_N_O(cu_n),
      .RD_WR_O(we_n), .BYTE_MASK_O(dqm), .ADDR_O(addr), .DATA_I(dq_in), .DATA_O(dq_out),
      .DATA_OE_O(oe));
   sdi_sdram_model mem_model (.clk_i(bclk), .cke_i(cke), .s2_n_i(s2_n), .s3_n_i(s3_n),
      .rl_n_i(rl_n), .ru_n_i(ru_n), .cl_n_i(cl_n), .cu_n_i(cu_n), .we_n_i(we_n),
      .dqm_i(dqm), .a_i(addr), .dq_i(dq_out), .dq_o(dq_in));
   ////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %0t: %h vs %h", $time, seen, exp);
      end
   endtask
   // apb transfer
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (rdy !== 1'b1 && ++n < 40);
      rdata = prd;
      err = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic run(input logic [3:0] op, input logic [3:0] be, input logic b, input logic ap);
      apb(1'b1, SDI_OFF_CMD, {22'h0, ap, b, be, op});
      for (int i = 0; i < 99; i++) begin
         apb(1'b0, SDI_OFF_STATUS, 32'h0);
         if (rdata[SDI_ST_BUSY] === 1'b0) break;
      end
   endtask
   task automatic cfg(input logic [2:0] t, input logic w, input logic [3:0] x, input logic le,
         input logic [31:0] a);
      apb(1'b1, SDI_OFF_CTRL, {20'h0, 2'b01, 1'b0, le, x, w, t});
      apb(1'b1, SDI_OFF_ADDR, a);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_refuse();
      int w0 = mem_model.wcount;
      apb(1'b0, SDI_OFF_CTRL, 32'h0);
      chk(rdata, SDI_CTRL_RESET);
      apb(1'b0, 8'h10, 32'h0);
      chk(err, 1'b1);
      for (int i = 0; i < 3; i++) begin
         cfg(i == 0 ? 3'b000 : 3'b010, 1'b1, 4'h5, 1'b0, i == 2 ? A : A & 32'hfbff_ffff);
         if (i == 2) apb(1'b1, SDI_OFF_CTRL, 32'h0000_060b);
         run(SDI_OP_WRITE, 4'hf, 1'b0, 1'b0);
         apb(1'b0, SDI_OFF_STATUS, 32'h0);
         chk(rdata[SDI_ST_REFUSED], 1'b1);
         apb(1'b1, SDI_OFF_STATUS, 32'h2);
      end
      chk(mem_model.wcount - w0, 0);
   endtask
   task automatic t_single();
      logic [3:0] be;
      int w0;
      for (int i = 0; i < 4; i++) begin
         be = i[0] ? 4'h8 : 4'h1;
         cfg(3'b011, 1'b1, 4'h5, i[1], A);
         w0 = mem_model.wcount;
         run(SDI_OP_WRITE, be, 1'b0, 1'b0);
         chk(mem_model.wcount - w0, 1);
         chk(mem_model.last_mask, i % 3 ? 4'he : 4'h7);
      end
      apb(1'b1, SDI_OFF_BUF, 32'h8bad_f00d);
      run(SDI_OP_WRITE, 4'hf, 1'b0, 1'b1);
      chk({mem_model.row_a[8:1], mem_model.col_a[8:1]}, {A[17:10], A[8:1]});
      chk(mem_model.col_a[12], 1'b1);
      apb(1'b1, SDI_OFF_BUF, 32'h0);
      run(SDI_OP_READ, 4'hf, 1'b0, 1'b1);
      apb(1'b0, SDI_OFF_BUF, 32'h0);
      chk(rdata, 32'h8bad_f00d);
   endtask
   task automatic t_burst();
      int w0;
      for (int w = 0; w < 2; w++) begin
         cfg(3'b011, w[0], 4'h5, 1'b0, A);
         w0 = mem_model.wcount;
         run(SDI_OP_WRITE, 4'hf, 1'b1, 1'b0);
         chk(mem_model.wcount - w0, w ? 4 : 8);
      end
   endtask
   task automatic t_halves();
      for (int i = 0; i < 2; i++) begin
         cfg(3'b011, 1'b1, i ? 4'hd : 4'h5, 1'b0, A | 32'h0200_0000);
         run(SDI_OP_WRITE, 4'hf, 1'b0, 1'b0);
         chk(mem_model.row_up, i == 0);
      end
   endtask
   task automatic t_special();
      cfg(3'b011, 1'b1, 4'h5, 1'b0, 32'h0000_0020);
      run(SDI_OP_REF, 4'h0, 1'b0, 1'b0);
      run(SDI_OP_PRECHARGE_ALL_CMD, 4'h0, 1'b0, 1'b0);
      run(SDI_OP_MRS, 4'h0, 1'b0, 1'b0);
      chk(mem_model.mrs_a, 26'h20);
      run(SDI_OP_SELF, 4'h0, 1'b0, 1'b0);
      repeat (16) @(posedge clk);
      chk(cke, 1'b0);
      run(SDI_OP_NOP, 4'h0, 1'b0, 1'b0);
      repeat (16) @(posedge clk);
      chk(cke, 1'b1);
   endtask
   ////////
   task automatic print_verdict();
      if (bad_count == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      t_refuse();
      t_single();
      t_burst();
      t_halves();
      t_special();
      print_verdict();
   end
   // hang guard
   initial begin
      #300000;
      bad_count++;
      print_verdict();
   end
endmodule
